// >>> sdram_model.sv
// partner model: memory side that answers fetch requests and takes result words
module sdram_model (
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  // fetch side
  input  wire logic        rdReqValid,
  input  wire logic [31:0] rdReqAddr,
  output logic             rdDataValid,
  output logic [63:0]      rdData,
  // store side
  output logic             wrDataReady,
  // pacing, high gives one word every other cycle
  input  wire logic        slow
);
  timeunit 1ns;
  timeprecision 1ps;
  logic phase_q = 1'b0;
  logic give;
  assign give = !slow || phase_q;
  // off-cycle data is inverted so a stale word never looks valid
  always @(posedge sys_clk) begin
    phase_q <= ~phase_q;
    if (!rst_n) begin
      rdDataValid <= 1'b0;
      rdData <= 64'h0;
      wrDataReady <= 1'b0;
    end else begin
      rdDataValid <= give && rdReqValid;
      rdData <= (give && rdReqValid) ? {rdReqAddr, rdData[31:0] + 32'h1} : ~rdData;
      wrDataReady <= give;
    end
  end
endmodule // sdram_model

// >>> test_video_convert_fetch_config.sv
// testbench: registers, frame fetch addressing and suspend handling of the fetch block
module test_video_convert_fetch_config
  import video_fetch_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        sys_clk = 1'b0;
  logic        rst_n = 1'b0;
  axi_req_type axiIn = '0;
  axi_rsp_type axiOut;
  logic        emuSuspend = 1'b0;
  logic        slow = 1'b0;
  logic        rdPrev = 1'b0;
  logic        rdReqValid, rdDataValid, wrDataValid, wrDataReady, wrReqPulse, resultLayout;
  logic [31:0] rdReqAddr, wrReqAddr, rdVal;
  logic [8:0]  rdReqBytes, wrReqBytes;
  logic [63:0] rdData, wrData;
  logic [1:0]  resp;
  logic [31:0] addrQ[$];
  int          nErrors = 0;
  int          nChecks = 0;
  int          nStores = 0;
  int          hardStores = 0;
  logic        hRdReqValid, hRdDataValid, hWrDataReady, hWrReqPulse;
  logic [31:0] hRdReqAddr;
  logic [63:0] hRdData;

  always #12.5 sys_clk = ~sys_clk;

  video_convert_fetch_config #(.FRAME_LINES(2)) dut (
    .sys_clk(sys_clk), .rst_n(rst_n), .axiIn(axiIn), .axiOut(axiOut),
    .emuSuspend(emuSuspend), .rdReqValid(rdReqValid), .rdReqAddr(rdReqAddr),
    .rdReqBytes(rdReqBytes), .rdDataValid(rdDataValid), .rdData(rdData),
    .wrDataValid(wrDataValid), .wrData(wrData), .wrDataReady(wrDataReady),
    .wrReqPulse(wrReqPulse), .wrReqAddr(wrReqAddr), .wrReqBytes(wrReqBytes),
    .resultLayout(resultLayout));

  sdram_model memory (
    .sys_clk(sys_clk), .rst_n(rst_n), .rdReqValid(rdReqValid), .rdReqAddr(rdReqAddr),
    .rdDataValid(rdDataValid), .rdData(rdData), .wrDataReady(wrDataReady), .slow(slow));

  // second copy with a writable stop kind, to watch the hard stop
  video_convert_fetch_config #(.FRAME_LINES(2), .SOFT_STOP_ONLY(1'b0)) hardDut (
    .sys_clk(sys_clk), .rst_n(rst_n), .axiIn(axiIn), .axiOut(),
    .emuSuspend(emuSuspend), .rdReqValid(hRdReqValid), .rdReqAddr(hRdReqAddr),
    .rdReqBytes(), .rdDataValid(hRdDataValid), .rdData(hRdData),
    .wrDataValid(), .wrData(), .wrDataReady(hWrDataReady),
    .wrReqPulse(hWrReqPulse), .wrReqAddr(), .wrReqBytes(), .resultLayout());

  sdram_model hardMemory (
    .sys_clk(sys_clk), .rst_n(rst_n), .rdReqValid(hRdReqValid), .rdReqAddr(hRdReqAddr),
    .rdDataValid(hRdDataValid), .rdData(hRdData), .wrDataReady(hWrDataReady), .slow(slow));

  // ==========================================================================
  // helpers
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    nChecks++;
    if (got !== exp) begin
      nErrors++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    axiIn.awaddr <= a;
    axiIn.wdata <= d;
    axiIn.wstrb <= 4'hf;
    axiIn.awvalid <= 1'b1;
    axiIn.wvalid <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (axiIn.awvalid && axiOut.awready) axiIn.awvalid <= 1'b0;
      if (axiIn.wvalid && axiOut.wready) axiIn.wvalid <= 1'b0;
    end while (axiOut.bvalid !== 1'b1);
    resp = axiOut.bresp;
  endtask

  task automatic rd(input logic [7:0] a);
    axiIn.araddr <= a;
    axiIn.arvalid <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (axiIn.arvalid && axiOut.arready) axiIn.arvalid <= 1'b0;
    end while (axiOut.rvalid !== 1'b1);
    rdVal = axiOut.rdata;
    resp = axiOut.rresp;
  endtask

  // fetch request starts and store pulses
  always @(posedge sys_clk) begin
    rdPrev <= rdReqValid;
    if (rdReqValid && !rdPrev) begin
      addrQ.push_back(rdReqAddr);
      chk({23'h0, rdReqBytes}, 32'h20);
    end
    if (wrDataValid && wrDataReady) chk(wrData[63:32], addrQ[nStores]);
    if (wrReqPulse) begin
      chk(wrReqAddr, addrQ[nStores]);
      nStores++;
      chk({23'h0, wrReqBytes}, 32'h20);
    end
    if (hWrReqPulse) hardStores++;
  end

  // ==========================================================================
  // scenarios
  task automatic t_regs();
    rd(OFS_EMU_SUSPEND);
    chk(rdVal, 32'h2);
    wr(OFS_EMU_SUSPEND, 32'h0);
    rd(OFS_EMU_SUSPEND);
    chk(rdVal, 32'h2);
    wr(OFS_REQUEST_UNIT, 32'hffff_ffff);
    rd(OFS_REQUEST_UNIT);
    chk(rdVal, 32'h1ff);
    wr(OFS_STORE_FORMAT, 32'hffff_ffff);
    rd(OFS_STORE_FORMAT);
    chk(rdVal, 32'h3);
    chk({31'h0, resultLayout}, 32'h1);
    wr(OFS_LUMA_BOT_BASE, 32'hffff_ffff);
    rd(OFS_LUMA_BOT_BASE);
    chk(rdVal, 32'hffff_ffff);
    rd(OFS_STATUS_CLEAR);
    chk(rdVal, 32'h0);
    wr(8'h40, 32'h1);
    chk({30'h0, resp}, {30'h0, RESP_SLVERR});
    rd(8'h40);
    chk({30'h0, resp}, {30'h0, RESP_SLVERR});
    wr(OFS_FRAME_CONTROL, 32'h1);
    repeat (20) @(posedge sys_clk);
    rd(OFS_FRAME_CONTROL);
    chk(rdVal, 32'h0);
    chk(32'(addrQ.size()), 32'h0);
    $display("test registers done");
  endtask

  task automatic run_frame(input logic [31:0] fmt, input logic [31:0] addr1);
    wr(OFS_STORE_FORMAT, fmt);
    wr(OFS_LUMA_TOP_STRIDE, 32'h100);
    wr(OFS_HORIZ_UNIT, 32'h20);
    addrQ.delete();
    nStores = 0;
    wr(OFS_FRAME_CONTROL, 32'h1);
    // stride change while running must not reach this frame
    wr(OFS_LUMA_TOP_STRIDE, 32'h300);
    rd(OFS_FRAME_CONTROL);
    chk(rdVal, 32'h1);
    rd(OFS_FRAME_STATUS);
    chk(rdVal, 32'h0);
    do rd(OFS_FRAME_CONTROL); while (rdVal[0] !== 1'b0);
    chk(32'(addrQ.size()), 32'h2);
    chk(addrQ[0], 32'h1000);
    chk(addrQ[1], addr1);
    chk(32'(nStores), 32'h2);
    rd(OFS_FRAME_STATUS);
    chk(rdVal, 32'h1);
    wr(OFS_STATUS_CLEAR, 32'h1);
    rd(OFS_FRAME_STATUS);
    chk(rdVal, 32'h0);
    $display("test frame format %h done", fmt);
  endtask

  task automatic t_frames();
    wr(OFS_LUMA_TOP_BASE, 32'h1000);
    wr(OFS_LUMA_TOP_WIDTH, 32'h20);
    wr(OFS_REQUEST_UNIT, 32'h20);
    slow <= 1'b1;
    run_frame(32'h0, 32'h1100);
    slow <= 1'b0;
    run_frame(32'h3, 32'h1020);
    chk({31'h0, resultLayout}, 32'h1);
    emuSuspend <= 1'b1;
    wr(OFS_EMU_SUSPEND, 32'h1);
    slow <= 1'b1;
    run_frame(32'h0, 32'h1100);
    emuSuspend <= 1'b0;
    $display("test frames done");
  endtask

  // suspend raised just after go: soft copy ends the frame, hard copy stops after one unit
  task automatic t_suspend();
    wr(OFS_EMU_SUSPEND, 32'h0);
    addrQ.delete();
    nStores = 0;
    hardStores = 0;
    wr(OFS_FRAME_CONTROL, 32'h1);
    emuSuspend <= 1'b1;
    do rd(OFS_FRAME_CONTROL); while (rdVal[0] !== 1'b0);
    chk(32'(nStores), 32'h2);
    chk(32'(hardStores), 32'h1);
    emuSuspend <= 1'b0;
    repeat (60) @(posedge sys_clk);
    chk(32'(hardStores), 32'h2);
    $display("test suspend done");
  endtask

  // ==========================================================================
  // run control
  task automatic final_report();
    $display("checks %0d mismatches %0d", nChecks, nErrors);
    if (nErrors == 0 && nChecks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  initial begin
    repeat (4) @(posedge sys_clk);
    rst_n <= 1'b1;
    axiIn.bready <= 1'b1;
    axiIn.rready <= 1'b1;
    @(posedge sys_clk);
    t_regs();
    t_frames();
    t_suspend();
    final_report();
  end

  initial begin
    repeat (30000) @(posedge sys_clk);
    nErrors++;
    final_report();
  end
endmodule // test_video_convert_fetch_config

// >>> video_convert_fetch_config.sv
// module: register bank, suspend handling and ping-pong fetch/store sequencer
// Function
// - writing one to frame_done_clear clears frame_done_flag; zero does nothing; reads zero.
// - suspend_stop_kind always holds and reads one, finish-the-frame suspend only; with SOFT_STOP_ONLY cleared it is writable.
// - hard stop halts after the current transfer completes, even mid-frame.
// - soft stop finishes the current frame, then holds off further frames.
// - suspend_free_run one ignores suspend; zero obeys the stop kind.
// - result_layout_select picks raster (0) or sub-picture (1) result layout.
// - source_layout_select picks raster (0) or sub-picture (1) source layout.
// - separate 64-bit by 64-word ping-pong buffer for read and write sides.
// - request raised when bytes stored or sent reach the request unit.
// - transfer_request_unit is 9 bits: 20h, 40h, 80h, 100h; others reserved.
// - each request is limited to the internal request size when smaller.
// - horizontal_unit_bytes is 9 bits: 10h to 100h bytes per pass.
// - zero horizontal_unit_bytes prevents the frame from starting.
// - full 32-bit luma base addresses for top and bottom fields.
// - luma_top_subpicture_pixels takes 10h to 100h pixels.
// - raster line address is base plus line offset times line index.
// - sub-picture source layout ignores the line offset.
// - frame_go starts one frame, reads one while busy, busy writes ignored.
// - frame_done_flag reads one after a finished frame until cleared, zero while busy.
//
// Local design decisions: the placing of the registers and the AXI4-Lite slave port.
module video_convert_fetch_config
  import video_fetch_pkg::*;
#(
  parameter int         FRAME_LINES       = 16,
  parameter logic [8:0] INTERNAL_REQ_SIZE = 9'h100,
  parameter bit         SOFT_STOP_ONLY    = 1'b1
) (
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  // register bus
  input  wire axi_req_type axiIn,
  output axi_rsp_type      axiOut,
  // emulation suspend pin
  input  wire logic        emuSuspend,
  // source fetch requests and returned data
  output logic             rdReqValid,
  output logic [31:0]      rdReqAddr,
  output logic [8:0]       rdReqBytes,
  input  wire logic        rdDataValid,
  input  wire logic [63:0] rdData,
  // result store data and requests
  output logic             wrDataValid,
  output logic [63:0]      wrData,
  input  wire logic        wrDataReady,
  output logic             wrReqPulse,
  output logic [31:0]      wrReqAddr,
  output logic [8:0]       wrReqBytes,
  // layout of stored results
  output logic             resultLayout
);

  initial begin
    if (FRAME_LINES < 1 || FRAME_LINES > 65535)
      $error("FRAME_LINES out of range");
    if (INTERNAL_REQ_SIZE < UNIT_32 || INTERNAL_REQ_SIZE[2:0] != 3'b000)
      $error("INTERNAL_REQ_SIZE must be a word multiple of at least 32");
  end

  // ==========================================================================
  // helpers
  function automatic logic [31:0] lineAddress(input frame_cfg_type c, input logic sub,
                                              input logic [15:0] line, input logic [8:0] off);
    logic [31:0] step;
    step = sub ? 32'(c.spWidth) : c.stride;
    return c.base + 32'(step * 32'(line)) + 32'(off);
  endfunction

  function automatic logic [8:0] effectiveUnit(input frame_cfg_type c);
    logic [8:0] u;
    u = c.unitBytes;
    if (u != UNIT_32 && u != UNIT_64 && u != UNIT_128 && u != UNIT_256)
      u = UNIT_32;
    if (INTERNAL_REQ_SIZE < u) u = INTERNAL_REQ_SIZE;
    if (c.horizBytes < u && c.horizBytes >= BYTES_PER_WORD) u = c.horizBytes;
    return u;
  endfunction

  function automatic logic [31:0] strobeMerge(input logic [31:0] old, input logic [31:0] d,
                                              input logic [3:0] s);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) if (s[i]) r[i*8 +: 8] = d[i*8 +: 8];
    return r;
  endfunction

  // ==========================================================================
  // state
  typedef struct packed {
    state_type     state;
    logic          syncA;
    logic          syncB;
    logic          awHeld;
    logic [7:0]    awAddr;
    logic          wHeld;
    logic [31:0]   wData;
    logic [3:0]    wStrb;
    logic          bValid;
    logic [1:0]    bResp;
    logic          rValid;
    logic [31:0]   rData;
    logic [1:0]    rResp;
    logic          goPending;
    logic          fieldBottom;
    logic          freeRun;
    logic          stopKind;
    logic          resSub;
    logic          srcSub;
    logic [8:0]    reqUnit;
    logic [8:0]    procUnit;
    logic [31:0]   topBase;
    logic [8:0]    topWidth;
    logic [31:0]   topStride;
    logic [31:0]   botBase;
    logic          doneFlag;
    frame_cfg_type cfg;
    logic [15:0]   line;
    logic [8:0]    chunk;
    logic [5:0]    wordIdx;
    logic          bank;
    logic          wrPulse;
    logic [31:0]   wrAddr;
  } st_type;

  st_type st_q;
  st_type st_d;
  logic [BUF_BITS-1:0] rdBuf [BUF_WORDS];
  logic [BUF_BITS-1:0] wrBuf [BUF_WORDS];

  logic          suspended;
  logic          writeNow;
  logic          frameEnd;
  logic          lastWord;
  logic [8:0]    unitNow;
  logic [9:0]    nextChunk;
  logic [31:0]   wrWord;
  logic [31:0]   readWord;
  logic          readHit;
  logic          setDone;
  logic          clrDone;
  logic [5:0]    bufIdx;

  assign suspended = st_q.syncB && !st_q.freeRun;
  assign writeNow  = st_q.awHeld && st_q.wHeld && !st_q.bValid;
  assign unitNow   = effectiveUnit(st_q.cfg);
  assign lastWord  = ({st_q.wordIdx, 3'b000} + BYTES_PER_WORD) == {unitNow[8:3], 3'b000};
  assign nextChunk = {1'b0, st_q.chunk} + {1'b0, unitNow};
  assign frameEnd  = nextChunk >= 10'(st_q.cfg.horizBytes) && st_q.line == 16'(FRAME_LINES - 1);
  assign wrWord    = strobeMerge(32'h0000_0000, st_q.wData, st_q.wStrb);
  assign bufIdx    = {st_q.bank, st_q.wordIdx[4:0]};
  assign setDone   = st_q.state == ST_SEND && wrDataReady && lastWord && frameEnd;
  assign clrDone   = writeNow && st_q.awAddr == OFS_STATUS_CLEAR && wrWord[0];

  // ==========================================================================
  // register read mux
  always_comb begin
    readHit  = 1'b1;
    readWord = WORD_RESET;
    case ({axiIn.araddr[7:2], 2'b00})
      OFS_FRAME_CONTROL: begin
        readWord[BIT_FRAME_GO]     = st_q.goPending || st_q.state != ST_IDLE;
        readWord[BIT_FIELD_BOTTOM] = st_q.fieldBottom;
      end
      OFS_FRAME_STATUS:    readWord[0] = st_q.doneFlag;
      OFS_STATUS_CLEAR:    readWord = WORD_RESET;
      OFS_EMU_SUSPEND: begin
        readWord[BIT_FREE_RUN]  = st_q.freeRun;
        readWord[BIT_STOP_KIND] = st_q.stopKind;
      end
      OFS_STORE_FORMAT: begin
        readWord[BIT_SOURCE_SUB] = st_q.srcSub;
        readWord[BIT_RESULT_SUB] = st_q.resSub;
      end
      OFS_REQUEST_UNIT:    readWord[SIZE_MSB:0] = st_q.reqUnit;
      OFS_HORIZ_UNIT:      readWord[SIZE_MSB:0] = st_q.procUnit;
      OFS_LUMA_TOP_BASE:   readWord = st_q.topBase;
      OFS_LUMA_TOP_WIDTH:  readWord[SIZE_MSB:0] = st_q.topWidth;
      OFS_LUMA_TOP_STRIDE: readWord = st_q.topStride;
      OFS_LUMA_BOT_BASE:   readWord = st_q.botBase;
      default:             readHit = 1'b0;
    endcase
  end

  // ==========================================================================
  // next state
  always_comb begin
    st_d         = st_q;
    st_d.syncA   = emuSuspend;
    st_d.syncB   = st_q.syncA;
    st_d.wrPulse = 1'b0;
    // bus write channels
    if (axiIn.awvalid && !st_q.awHeld && !st_q.bValid) begin
      st_d.awHeld = 1'b1;
      st_d.awAddr = {axiIn.awaddr[7:2], 2'b00};
    end
    if (axiIn.wvalid && !st_q.wHeld && !st_q.bValid) begin
      st_d.wHeld = 1'b1;
      st_d.wData = axiIn.wdata;
      st_d.wStrb = axiIn.wstrb;
    end
    if (st_q.bValid && axiIn.bready) st_d.bValid = 1'b0;
    if (writeNow) begin
      st_d.awHeld = 1'b0;
      st_d.wHeld  = 1'b0;
      st_d.bValid = 1'b1;
      st_d.bResp  = RESP_OKAY;
      case (st_q.awAddr)
        OFS_FRAME_CONTROL: begin
          if (wrWord[BIT_FRAME_GO] && !st_q.goPending && st_q.state == ST_IDLE)
            st_d.goPending = 1'b1;
          if (st_q.wStrb[0]) st_d.fieldBottom = st_q.wData[BIT_FIELD_BOTTOM];
        end
        OFS_FRAME_STATUS, OFS_STATUS_CLEAR: ;
        OFS_EMU_SUSPEND: if (st_q.wStrb[0]) begin
          st_d.freeRun = st_q.wData[BIT_FREE_RUN];
          st_d.stopKind = SOFT_STOP_ONLY ? STOP_KIND_SOFT : st_q.wData[BIT_STOP_KIND];
        end
        OFS_STORE_FORMAT: if (st_q.wStrb[0]) begin
          st_d.srcSub = st_q.wData[BIT_SOURCE_SUB];
          st_d.resSub = st_q.wData[BIT_RESULT_SUB];
        end
        OFS_REQUEST_UNIT:    st_d.reqUnit = 9'(strobeMerge(32'(st_q.reqUnit), st_q.wData, st_q.wStrb));
        OFS_HORIZ_UNIT:      st_d.procUnit = 9'(strobeMerge(32'(st_q.procUnit), st_q.wData, st_q.wStrb));
        OFS_LUMA_TOP_BASE:   st_d.topBase = strobeMerge(st_q.topBase, st_q.wData, st_q.wStrb);
        OFS_LUMA_TOP_WIDTH:  st_d.topWidth = 9'(strobeMerge(32'(st_q.topWidth), st_q.wData, st_q.wStrb));
        OFS_LUMA_TOP_STRIDE: st_d.topStride = strobeMerge(st_q.topStride, st_q.wData, st_q.wStrb);
        OFS_LUMA_BOT_BASE:   st_d.botBase = strobeMerge(st_q.botBase, st_q.wData, st_q.wStrb);
        default:             st_d.bResp = RESP_SLVERR;
      endcase
    end
    // bus read channel
    if (st_q.rValid && axiIn.rready) st_d.rValid = 1'b0;
    if (axiIn.arvalid && !st_q.rValid) begin
      st_d.rValid = 1'b1;
      st_d.rData  = readWord;
      st_d.rResp  = readHit ? RESP_OKAY : RESP_SLVERR;
    end
    // frame status: set wins over clear
    if (clrDone) st_d.doneFlag = 1'b0;
    // sequencer
    case (st_q.state)
      ST_IDLE: begin
        if (st_q.goPending && st_q.procUnit == SIZE_RESET)
          st_d.goPending = 1'b0;
        else if (st_q.goPending && !suspended) begin
          st_d.goPending      = 1'b0;
          st_d.doneFlag       = 1'b0;
          st_d.cfg.srcSub     = st_q.srcSub;
          st_d.cfg.resSub     = st_q.resSub;
          st_d.cfg.unitBytes  = st_q.reqUnit;
          st_d.cfg.horizBytes = st_q.procUnit;
          st_d.cfg.base       = st_q.fieldBottom ? st_q.botBase : st_q.topBase;
          st_d.cfg.stride     = st_q.topStride;
          st_d.cfg.spWidth    = st_q.topWidth;
          st_d.line           = 16'h0000;
          st_d.chunk          = 9'h000;
          st_d.wordIdx        = 6'h00;
          st_d.state          = ST_FETCH;
        end
      end
      ST_FETCH: if (rdDataValid) begin
        if (lastWord) begin
          st_d.wordIdx = 6'h00;
          st_d.state   = ST_SEND;
        end else begin
          st_d.wordIdx = st_q.wordIdx + 6'h01;
        end
      end
      ST_SEND: if (wrDataReady) begin
        if (lastWord) begin
          st_d.wordIdx = 6'h00;
          st_d.wrPulse = 1'b1;
          st_d.wrAddr  = lineAddress(st_q.cfg, st_q.cfg.resSub, st_q.line, st_q.chunk);
          st_d.bank    = !st_q.bank;
          if (nextChunk >= 10'(st_q.cfg.horizBytes)) begin
            st_d.chunk = 9'h000;
            st_d.line  = st_q.line + 16'h0001;
          end else begin
            st_d.chunk = nextChunk[8:0];
          end
          if (frameEnd) begin
            st_d.doneFlag = 1'b1;
            st_d.state    = ST_IDLE;
          end else if (suspended && !st_q.stopKind) begin
            st_d.state = ST_HALT;
          end else begin
            st_d.state = ST_FETCH;
          end
        end else begin
          st_d.wordIdx = st_q.wordIdx + 6'h01;
        end
      end
      ST_HALT: if (!suspended) st_d.state = ST_FETCH;
      default: st_d.state = ST_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      st_q          <= '0;
      st_q.state    <= ST_IDLE;
      st_q.stopKind <= STOP_KIND_SOFT;
      st_q.reqUnit  <= SIZE_RESET;
      st_q.procUnit <= SIZE_RESET;
    end else begin
      st_q <= st_d;
    end
  end

  // ping-pong buffers: source words pass unchanged into the result half
  always_ff @(posedge sys_clk) begin
    if (st_q.state == ST_FETCH && rdDataValid) begin
      rdBuf[bufIdx] <= rdData;
      wrBuf[bufIdx] <= rdData;
    end
  end

  // ==========================================================================
  // outputs
  assign axiOut.awready = !st_q.awHeld && !st_q.bValid;
  assign axiOut.wready  = !st_q.wHeld && !st_q.bValid;
  assign axiOut.bvalid  = st_q.bValid;
  assign axiOut.bresp   = st_q.bResp;
  assign axiOut.arready = !st_q.rValid;
  assign axiOut.rvalid  = st_q.rValid;
  assign axiOut.rdata   = st_q.rData;
  assign axiOut.rresp   = st_q.rResp;
  assign rdReqValid     = st_q.state == ST_FETCH;
  assign rdReqAddr      = lineAddress(st_q.cfg, st_q.cfg.srcSub, st_q.line, st_q.chunk);
  assign rdReqBytes     = unitNow;
  assign wrDataValid    = st_q.state == ST_SEND;
  assign wrData         = wrBuf[bufIdx];
  assign wrReqPulse     = st_q.wrPulse;
  assign wrReqAddr      = st_q.wrAddr;
  assign wrReqBytes     = unitNow;
  assign resultLayout   = st_q.resSub;

  // ==========================================================================
  // checks
  chk_stop_kind_fixed: assert property (@(posedge sys_clk) disable iff (!rst_n)
    SOFT_STOP_ONLY |-> st_q.stopKind) else $error("stop kind not one");
  chk_free_no_halt: assert property (@(posedge sys_clk) disable iff (!rst_n)
    st_q.freeRun && st_q.state == ST_SEND |=> st_q.state != ST_HALT)
    else $error("halted while free running");
  chk_zero_unit_blocks: assert property (@(posedge sys_clk) disable iff (!rst_n)
    st_q.state == ST_IDLE && st_q.goPending && st_q.procUnit == SIZE_RESET
    |=> st_q.state == ST_IDLE && !st_q.goPending) else $error("started with zero unit");
  chk_done_after_frame: assert property (@(posedge sys_clk) disable iff (!rst_n)
    setDone |=> st_q.doneFlag && st_q.state == ST_IDLE ##1 wrReqPulse == 1'b0)
    else $error("frame end did not set done");
  chk_clear_done: assert property (@(posedge sys_clk) disable iff (!rst_n)
    clrDone && !setDone |=> !st_q.doneFlag) else $error("status clear ignored");
  chk_request_limit: assert property (@(posedge sys_clk) disable iff (!rst_n)
    rdReqValid |-> rdReqBytes <= INTERNAL_REQ_SIZE && rdReqBytes <= UNIT_256)
    else $error("request above internal size");
  chk_sub_ignores_stride: assert property (@(posedge sys_clk) disable iff (!rst_n)
    rdReqValid && st_q.cfg.srcSub |-> rdReqAddr ==
      st_q.cfg.base + 32'(32'(st_q.cfg.spWidth) * 32'(st_q.line)) + 32'(st_q.chunk))
    else $error("sub-picture address used stride");
  chk_soft_hold_off: assert property (@(posedge sys_clk) disable iff (!rst_n)
    st_q.state == ST_IDLE && suspended |=> st_q.state == ST_IDLE)
    else $error("frame started under suspend");
  chk_busy_status: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $rose(st_q.state == ST_FETCH) && $past(st_q.state) == ST_IDLE |-> !st_q.doneFlag)
    else $error("done flag high while busy");

endmodule // video_convert_fetch_config

// >>> video_fetch_pkg.sv
// package: register map, field layout, states and carrier types of the fetch configuration block
package video_fetch_pkg;

  // ==========================================================================
  // register byte offsets
  localparam logic [7:0] OFS_FRAME_CONTROL   = 8'h00;
  localparam logic [7:0] OFS_FRAME_STATUS    = 8'h04;
  localparam logic [7:0] OFS_STATUS_CLEAR    = 8'h08;
  localparam logic [7:0] OFS_EMU_SUSPEND     = 8'h0c;
  localparam logic [7:0] OFS_STORE_FORMAT    = 8'h10;
  localparam logic [7:0] OFS_REQUEST_UNIT    = 8'h14;
  localparam logic [7:0] OFS_HORIZ_UNIT      = 8'h18;
  localparam logic [7:0] OFS_LUMA_TOP_BASE   = 8'h1c;
  localparam logic [7:0] OFS_LUMA_TOP_WIDTH  = 8'h20;
  localparam logic [7:0] OFS_LUMA_TOP_STRIDE = 8'h24;
  localparam logic [7:0] OFS_LUMA_BOT_BASE   = 8'h28;

  // ==========================================================================
  // field positions
  localparam int BIT_FRAME_GO     = 0;
  localparam int BIT_FIELD_BOTTOM = 1;
  localparam int BIT_FREE_RUN     = 0;
  localparam int BIT_STOP_KIND    = 1;
  localparam int BIT_SOURCE_SUB   = 0;
  localparam int BIT_RESULT_SUB   = 1;
  localparam int SIZE_MSB         = 8;

  // ==========================================================================
  // reset values and sizes
  localparam logic [8:0]  SIZE_RESET     = 9'h000;
  localparam logic [31:0] WORD_RESET     = 32'h0000_0000;
  localparam logic        STOP_KIND_SOFT = 1'b1;
  localparam logic [8:0]  UNIT_32        = 9'h020;
  localparam logic [8:0]  UNIT_64        = 9'h040;
  localparam logic [8:0]  UNIT_128       = 9'h080;
  localparam logic [8:0]  UNIT_256       = 9'h100;
  localparam logic [8:0]  BYTES_PER_WORD = 9'h008;
  localparam int          BUF_WORDS      = 64;
  localparam int          BUF_BITS       = 64;
  localparam logic [1:0]  RESP_OKAY      = 2'b00;
  localparam logic [1:0]  RESP_SLVERR    = 2'b10;

  typedef enum logic [1:0] {ST_IDLE, ST_FETCH, ST_SEND, ST_HALT} state_type;

  // AXI4-Lite carriers, master to slave and back
  typedef struct packed {
    logic        awvalid;
    logic [7:0]  awaddr;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
    logic        arvalid;
    logic [7:0]  araddr;
    logic        rready;
  } axi_req_type;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } axi_rsp_type;

  // frame configuration captured at start
  typedef struct packed {
    logic        srcSub;
    logic        resSub;
    logic [8:0]  unitBytes;
    logic [8:0]  horizBytes;
    logic [31:0] base;
    logic [31:0] stride;
    logic [8:0]  spWidth;
  } frame_cfg_type;

endpackage
